//--- logic/dcio_pkg.sv
// Package of constants and types for the dual processor on-board I/O ports
`default_nettype none
package dcio_pkg;
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned BASE_W          = 6;
    localparam logic [1:0]  OFS_SWAP_LATCH  = 2'h1;
    localparam logic [1:0]  OFS_JUMPER_MODE = 2'h3;
    localparam logic [5:0]  BASE_DEFAULT    = 6'h3F;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;
    localparam logic [1:0]  MODE_RESET      = 2'h0;
    localparam logic        CPU_RESET       = 1'b0;
    localparam logic [7:0]  DATA_ZERO       = 8'h00;

    // Memory management modes
    typedef enum logic [1:0] {
        DCIO_MODE_DEFAULT,
        DCIO_MODE_VIRTUAL,
        DCIO_MODE_WIDE_PRIMARY,
        DCIO_MODE_BYTE_PRIMARY
    } dcio_mode_t;
endpackage : dcio_pkg
`default_nettype wire

//--- logic/dcio_ports.sv
// On-board I/O port decoder: processor swap, bank latch, jumpers and mode
`default_nettype none
module dcio_ports (
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_resetn,
    // I/O cycle from the active processor, one-cycle strobes
    input  wire logic [15:0]                i_io_addr,
    input  wire logic                       i_io_rd,
    input  wire logic                       i_io_wr,
    input  wire logic [7:0]                 i_io_wdata,
    // Jumpers from pins
    input  wire logic [dcio_pkg::BASE_W-1:0] i_port_group_base,
    input  wire logic                       i_option_jumper_one,
    input  wire logic                       i_option_jumper_zero,
    // Read answer
    output logic [7:0]                      o_io_rdata,
    output logic                            o_io_rdata_oe,
    // Block state
    output logic                            o_wide_cpu_active,
    output logic [7:0]                      o_bank_latch,
    output dcio_pkg::dcio_mode_t            o_mm_mode
);
    import dcio_pkg::*;

    // All state in one record: pin synchronisers, owner, latch, mode and read answer
    typedef struct packed {
        logic [5:0] base_s1;
        logic [5:0] base_s2;
        logic [1:0] jmp_s1;
        logic [1:0] jmp_s2;
        logic       wide_cpu;
        logic [7:0] latch;
        dcio_mode_t mode;
        logic [7:0] rdata;
        logic       rdata_oe;
    } dcio_state_t;

    // Registered state, its next value and the decode terms shared with the checks
    dcio_state_t st_q;
    dcio_state_t st_d;
    logic        hit;
    logic [1:0]  ofs;

    // Decode and next state; jumpers pass two flops since they are pins
    always_comb begin
        st_d         = st_q;
        st_d.base_s1 = i_port_group_base;
        st_d.base_s2 = st_q.base_s1;
        st_d.jmp_s1  = {i_option_jumper_one, i_option_jumper_zero};
        st_d.jmp_s2  = st_q.jmp_s1;
        // Read answer is a one-cycle pulse, quiet by default
        st_d.rdata    = DATA_ZERO;
        st_d.rdata_oe = 1'b0;
        // Upper address bits never take part; even offsets stay free for others
        ofs = i_io_addr[1:0];
        hit = (i_io_addr[ADDR_W-1:2] == st_q.base_s2) && ofs[0];
        // Read wins when both strobes come together, so a write is then dropped
        if (hit && i_io_rd) begin
            st_d.rdata_oe = 1'b1;
            if (ofs == OFS_SWAP_LATCH) begin
                st_d.wide_cpu = ~st_q.wide_cpu;
            end else begin
                st_d.rdata = {6'h00, st_q.jmp_s2};
            end
        end else if (hit && i_io_wr) begin
            if (ofs == OFS_SWAP_LATCH) begin
                st_d.latch = i_io_wdata;
            end else begin
                st_d.mode = dcio_mode_t'(i_io_wdata[1:0]);
            end
        end
    end

    // State register; constants only under reset
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q.base_s1  <= BASE_DEFAULT;
            st_q.base_s2  <= BASE_DEFAULT;
            st_q.jmp_s1   <= 2'h0;
            st_q.jmp_s2   <= 2'h0;
            st_q.wide_cpu <= CPU_RESET;
            st_q.latch    <= LATCH_RESET;
            st_q.mode     <= DCIO_MODE_DEFAULT;
            st_q.rdata    <= DATA_ZERO;
            st_q.rdata_oe <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_io_rdata        = st_q.rdata;
    assign o_io_rdata_oe     = st_q.rdata_oe;
    assign o_wide_cpu_active = st_q.wide_cpu;
    assign o_bank_latch      = st_q.latch;
    assign o_mm_mode         = st_q.mode;

    // Checks
    // Claimed swap read hands the bus to the other processor
    property p_swap;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (hit && i_io_rd && ofs == OFS_SWAP_LATCH) |=> (o_wide_cpu_active != $past(o_wide_cpu_active));
    endproperty
    a_swap: assert property (p_swap) else $error("swap read did not toggle owner");

    // Claimed write to the swap port loads the latch
    property p_latch;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (hit && i_io_wr && !i_io_rd && ofs == OFS_SWAP_LATCH) |=> (o_bank_latch == $past(i_io_wdata));
    endproperty
    a_latch: assert property (p_latch) else $error("latch not loaded");

    // Claimed write to the mode port takes data bits 1:0 only
    property p_mode;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (hit && i_io_wr && !i_io_rd && ofs == OFS_JUMPER_MODE) |=> (o_mm_mode == $past(i_io_wdata[1:0]));
    endproperty
    a_mode: assert property (p_mode) else $error("mode not set");

    // Jumper read answers with the synchronised pin levels
    property p_jump;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (hit && i_io_rd && ofs == OFS_JUMPER_MODE) |=> (o_io_rdata == {6'h00, $past(st_q.jmp_s2)}) && o_io_rdata_oe;
    endproperty
    a_jump: assert property (p_jump) else $error("jumper read wrong");

    // Even offsets are left to other boards and the coprocessor
    property p_even;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (!i_io_addr[0]) |=> !o_io_rdata_oe && $stable(o_bank_latch) && $stable(o_mm_mode)
            && $stable(o_wide_cpu_active);
    endproperty
    a_even: assert property (p_even) else $error("even port claimed");

    // Foreign groups see no answer and no side effect
    property p_miss;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_io_addr[7:2] != st_q.base_s2) |=> !o_io_rdata_oe && $stable(o_bank_latch) && $stable(o_mm_mode)
            && $stable(o_wide_cpu_active);
    endproperty
    a_miss: assert property (p_miss) else $error("foreign port claimed");

    // Upper address bits do not spoil a claimed read
    property p_high;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_io_rd && i_io_addr[7:0] == {st_q.base_s2, OFS_JUMPER_MODE}) |=> o_io_rdata_oe;
    endproperty
    a_high: assert property (p_high) else $error("high bits affected decode");

    // Data bus held at zero whenever it is not driven
    property p_quiet;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !o_io_rdata_oe |-> (o_io_rdata == DATA_ZERO);
    endproperty
    a_quiet: assert property (p_quiet) else $error("data driven while idle");

    // Owner only moves on a claimed swap read
    property p_owner_hold;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !(hit && i_io_rd && ofs == OFS_SWAP_LATCH) |=> $stable(o_wide_cpu_active);
    endproperty
    a_owner_hold: assert property (p_owner_hold) else $error("owner moved without swap read");

    // Latch only moves on a claimed write to the swap port
    property p_latch_hold;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !(hit && i_io_wr && !i_io_rd && ofs == OFS_SWAP_LATCH) |=> $stable(o_bank_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved without write");

    // Mode only moves on a claimed write to the mode port
    property p_mode_hold;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !(hit && i_io_wr && !i_io_rd && ofs == OFS_JUMPER_MODE) |=> $stable(o_mm_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved without write");

    // Swap read drives the bus, with an all-zero answer
    property p_swap_zero;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (hit && i_io_rd && ofs == OFS_SWAP_LATCH) |=> o_io_rdata_oe && (o_io_rdata == DATA_ZERO);
    endproperty
    a_swap_zero: assert property (p_swap_zero) else $error("swap read answer not zero");

    // Read answer lasts one cycle unless another claimed read follows
    property p_oe_pulse;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_io_rdata_oe && !(hit && i_io_rd) |=> !o_io_rdata_oe;
    endproperty
    a_oe_pulse: assert property (p_oe_pulse) else $error("read answer outlived its cycle");

    // Data is driven only after a claimed read
    property p_oe_cause;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_io_rdata_oe |-> $past(hit) && $past(i_io_rd);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("data driven without claimed read");

    // First edge after reset release shows the cleared state
    property p_reset_vals;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(i_resetn) |-> (o_wide_cpu_active == CPU_RESET) && (o_bank_latch == LATCH_RESET)
            && (o_mm_mode == MODE_RESET) && !o_io_rdata_oe;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("state not cleared by reset");

    // Main scenarios reached
    c_swap: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_wide_cpu_active);
    c_jump: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_io_rdata_oe && o_io_rdata != DATA_ZERO);
    c_back: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) $fell(o_wide_cpu_active));
    c_mode3: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_mm_mode == DCIO_MODE_BYTE_PRIMARY);
    c_latch: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_bank_latch != LATCH_RESET);
endmodule : dcio_ports
`default_nettype wire

//--- bench/dcio_cpu.sv
// Model of the active processor issuing I/O cycles
`default_nettype none
module dcio_cpu (
    // Clock
    input  wire logic   i_clk_sys,
    // I/O cycle
    output logic [15:0] o_io_addr,
    output logic        o_io_rd,
    output logic        o_io_wr,
    output logic [7:0]  o_io_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle until the first cycle
    initial {o_io_addr, o_io_wdata, o_io_rd, o_io_wr} = '0;
    // One strobe cycle; idle lines inverted so stale values never match
    task automatic cyc(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) #1;
        {o_io_addr, o_io_wdata, o_io_rd, o_io_wr} = {a, d, r, !r};
        @(posedge i_clk_sys) #1;
        {o_io_addr, o_io_wdata, o_io_rd, o_io_wr} = {~a, ~d, 2'b00};
    endtask : cyc
endmodule : dcio_cpu
`default_nettype wire

//--- bench/test_dcio_ports.sv
// Self-checking bench for the on-board I/O ports
`default_nettype none
module test_dcio_ports;
    timeunit 1ns;
    timeprecision 1ns;
    import dcio_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_resetn, rd, wr, oe, wide, j1, j0;
    logic [5:0]  base;
    logic [15:0] addr;
    logic [7:0]  wd, rdat, latch;
    dcio_mode_t  mode;
    int          errors, checks_done, cycles;
    // Processor model and block
    dcio_cpu i_dcio_cpu (.i_clk_sys, .o_io_addr(addr), .o_io_rd(rd), .o_io_wr(wr), .o_io_wdata(wd));
    dcio_ports i_dcio_ports (.i_clk_sys, .i_resetn, .i_io_addr(addr), .i_io_rd(rd), .i_io_wr(wr),
        .i_io_wdata(wd), .i_port_group_base(base), .i_option_jumper_one(j1), .i_option_jumper_zero(j0),
        .o_io_rdata(rdat), .o_io_rdata_oe(oe), .o_wide_cpu_active(wide), .o_bank_latch(latch), .o_mm_mode(mode));
    // Compare and count
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        errors += int'(s !== e);
        if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
    endtask : chk
    // Verdict
    task automatic close_out();
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // 50 MHz clock
    initial forever #10 i_clk_sys = ~i_clk_sys;
    // Hang guard, the run needs well under 200 cycles
    always @(posedge i_clk_sys) begin
        if (++cycles == 3000) begin
            errors++;
            close_out();
        end
    end
    // Swap there and back, upper address bits set on the way there only
    task automatic t_swap();
        i_dcio_cpu.cyc(1'b1, 16'hA5FD, 8'h00);
        chk("oe", 8'(oe), 8'h01);
        chk("owner", 8'(wide), 8'h01);
        chk("rdata", rdat, 8'h00);
        i_dcio_cpu.cyc(1'b1, 16'h00FD, 8'h00);
        chk("owner", 8'(wide), 8'h00);
    endtask : t_swap
    // Latch load, then every mode with high data bits set
    task automatic t_write();
        i_dcio_cpu.cyc(1'b0, 16'h12FD, 8'hC3);
        chk("latch", latch, 8'hC3);
        for (int m = 1; m < 5; m++) begin
            i_dcio_cpu.cyc(1'b0, 16'h34FF, 8'hFC | 8'(m % 4));
            chk("mode", 8'(mode), 8'(m % 4));
        end
    endtask : t_write
    // Even ports, then a foreign base, leave state alone
    task automatic t_refuse();
        for (int a = 16'hF8; a < 16'h100; a += 2) begin
            i_dcio_cpu.cyc(1'b1, 16'(a), 8'h00);
            chk("oe", 8'(oe), 8'h00);
            i_dcio_cpu.cyc(1'b0, 16'(a), 8'h55);
        end
        chk("latch", latch, 8'hC3);
        chk("mode", 8'(mode), 8'h00);
        chk("owner", 8'(wide), 8'h00);
        base = 6'h20;
        repeat (2) @(posedge i_clk_sys); // Base pins pass two flops first
        i_dcio_cpu.cyc(1'b1, 16'h00FD, 8'h00);
        chk("owner", 8'(wide), 8'h00);
        i_dcio_cpu.cyc(1'b1, 16'h0081, 8'h00);
        chk("owner", 8'(wide), 8'h01);
    endtask : t_refuse
    // Jumper read answers on bits 1:0 with data driven
    task automatic t_jumper();
        i_dcio_cpu.cyc(1'b1, 16'h00FF, 8'h00);
        chk("jumpers", rdat, 8'h02);
        chk("oe", 8'(oe), 8'h01);
    endtask : t_jumper
    // Mid-run reset clears owner, latch and mode; base pins sit at 0x20 here
    task automatic t_reset();
        i_dcio_cpu.cyc(1'b0, 16'h0083, 8'h03);
        chk("mode", 8'(mode), 8'h03);
        i_resetn = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1 i_resetn = 1'b1;
        chk("owner", 8'(wide), 8'h00);
        chk("latch", latch, 8'h00);
        chk("mode", 8'(mode), 8'h00);
        repeat (2) @(posedge i_clk_sys);
        i_dcio_cpu.cyc(1'b1, 16'h0083, 8'h00);
        chk("jumpers", rdat, 8'h02);
    endtask : t_reset
    // Reset, jumpers, scenarios
    initial begin
        {i_resetn, j1, j0, base} = {3'b010, 6'h3F};
        repeat (4) @(posedge i_clk_sys);
        #1 i_resetn = 1'b1;
        chk("latch", latch, 8'h00);
        chk("owner", 8'(wide), 8'h00);
        t_swap();
        t_write();
        t_jumper();
        t_refuse();
        t_reset();
        close_out();
    end
endmodule : test_dcio_ports
`default_nettype wire
